// ==== rtl/iehm_params.svh ====
/*
 * Constants of the expander manager: counts, masks, register numbers.
 * Assumes inclusion by bare name from any design file that needs them.
 */
`ifndef IEHM_PARAMS_SVH
`define IEHM_PARAMS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define IEHM_CLK_HZ 20000000
`define IEHM_PERIOD_MS 40
// least time, so rounded up to whole cycles
`define IEHM_PERIOD_CYC (((`IEHM_PERIOD_MS * `IEHM_CLK_HZ) + 999) / 1000)
`define IEHM_TMR_W 20

// ----------------------------------------
// expander population
// ----------------------------------------
`define IEHM_NUM_EXP 5
`define IEHM_EXP_PG 3'h2
`define IEHM_EXP_LED 3'h4

// ----------------------------------------
// step masks, bit k is step k: w2 w3 w4 w5 w6 w7 r0 r1
// ----------------------------------------
`define IEHM_CFG_MASK 8'hff
`define IEHM_CFG_MASK_PG 8'hfd
`define IEHM_UPD_MASK 8'h03
`define IEHM_UPD_MASK_PG 8'h01
`define IEHM_RD_MASK 8'hc0
`define IEHM_STEP_OUT_LO 3'h0
`define IEHM_STEP_OUT_HI 3'h1
`define IEHM_STEP_DIR_LO 3'h4
`define IEHM_STEP_DIR_HI 3'h5
`define IEHM_STEP_RD_LO 3'h6
`define IEHM_STEP_RD_HI 3'h7
`define IEHM_REG_OUT_LO 3'h2
`define IEHM_REG_IN_LO 3'h0

// ----------------------------------------
// direction (1 = input) and negated output values
// ----------------------------------------
`define IEHM_DIR_HP 16'h0f0f
`define IEHM_DIR_PG 16'hff0f
`define IEHM_DIR_LED 16'h0000
`define IEHM_NEG_HP 8'h00
`define IEHM_NEG_LED 8'hff
`define IEHM_INV_DATA 8'h00

`endif

// ==== rtl/iehm_pkg.sv ====
/*
 * Types shared by the expander manager and its link crossing.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package iehm_pkg;

    // one byte-register transaction to an expander
    typedef struct packed {
        logic [6:0] addr;
        logic [2:0] reg_idx;
        logic write;
        logic [7:0] data;
    } iehm_txn_t;

    // answer of the bus engine
    typedef struct packed {
        logic [7:0] rdata;
        logic [3:0] err;
    } iehm_res_t;

    // sequencer states, gray along idle-send-wait
    typedef enum logic [1:0] {
        IEHM_IDLE = 2'h0,
        IEHM_SEND = 2'h1,
        IEHM_WAIT = 2'h3
    } iehm_state_t;

endpackage : iehm_pkg

// ==== rtl/iehm_xfer.sv ====
/*
 * Toggle handshake carrying one transaction into the link clock domain
 * and its answer back. Assumes the system side issues a new request only
 * after the previous done pulse; payloads stay stable while in flight.
 */
`timescale 1ns/1ps

module iehm_xfer (
    // system domain
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_req,
    input wire iehm_pkg::iehm_txn_t i_txn,
    output logic o_done,
    output iehm_pkg::iehm_res_t o_res,
    // link domain
    input wire logic i_clk_link,
    output logic o_lnk_valid,
    output iehm_pkg::iehm_txn_t o_lnk_txn,
    input wire logic i_lnk_done,
    input wire logic [7:0] i_lnk_rdata,
    input wire logic [3:0] i_lnk_err
);

    // ----------------------------------------
    // system side
    // ----------------------------------------
    logic req_tgl_r;
    logic ack_s1_r, ack_s2_r, ack_s3_r;
    iehm_pkg::iehm_txn_t txn_hold_r;
    iehm_pkg::iehm_res_t lnk_res_r;
    logic ack_tgl_r;

    // request toggles once per transaction, payload held for the crossing
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            req_tgl_r <= 1'b0;
            txn_hold_r <= '0;
        end else if (i_req) begin
            req_tgl_r <= ~req_tgl_r;
            txn_hold_r <= i_txn;
        end
    end

    // answer toggle synchroniser and result capture
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
            ack_s3_r <= 1'b0;
            o_done <= 1'b0;
            o_res <= '0;
        end else begin
            ack_s1_r <= ack_tgl_r;
            ack_s2_r <= ack_s1_r;
            ack_s3_r <= ack_s2_r;
            o_done <= ack_s2_r ^ ack_s3_r;
            if (ack_s2_r ^ ack_s3_r) begin
                o_res <= lnk_res_r; // written with the toggle, stable since
            end
        end
    end

    // ----------------------------------------
    // link side
    // ----------------------------------------
    logic lrst_s1_r, lrst_s2_r;
    logic req_s1_r, req_s2_r, req_s3_r;

    // reset brought into the link domain, released two edges late
    always_ff @(posedge i_clk_link) begin
        lrst_s1_r <= i_nrst;
        lrst_s2_r <= lrst_s1_r;
    end

    // engine request held until the engine reports done
    always_ff @(posedge i_clk_link) begin
        if (!lrst_s2_r) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            req_s3_r <= 1'b0;
            o_lnk_valid <= 1'b0;
            o_lnk_txn <= '0;
            lnk_res_r <= '0;
            ack_tgl_r <= 1'b0;
        end else begin
            req_s1_r <= req_tgl_r;
            req_s2_r <= req_s1_r;
            req_s3_r <= req_s2_r;
            if (req_s2_r ^ req_s3_r) begin
                o_lnk_valid <= 1'b1;
                o_lnk_txn <= txn_hold_r;
            end else if (o_lnk_valid && i_lnk_done) begin
                o_lnk_valid <= 1'b0;
                lnk_res_r <= '{rdata: i_lnk_rdata, err: i_lnk_err};
                ack_tgl_r <= ~ack_tgl_r;
            end
        end
    end

endmodule : iehm_xfer

// ==== rtl/iehm_top.sv ====
/*
 * Expander manager: keeps five 16-bit bus expanders in step with the
 * internal hot-plug and link indicator view, with debug access.
 * Assumes a byte-register bus engine on the link clock behind the
 * o_lnk_* / i_lnk_* handshake, and expander interrupts on raw pins.
 */
`timescale 1ns/1ps
`include "iehm_params.svh"

module iehm_top #(
    parameter logic [`IEHM_TMR_W-1:0] PERIOD_CYC = `IEHM_TMR_W'(`IEHM_PERIOD_CYC)
) (
    // clocks and reset
    input wire logic i_clk_sys,
    input wire logic i_clk_link,
    input wire logic i_nrst,
    // device phase
    input wire logic i_eeprom_done,
    input wire logic i_normal_op,
    input wire logic i_fund_reset,
    // expander setup and internal view
    input wire logic [4:0][6:0] i_expander_bus_address,
    input wire logic [4:0] i_exp_enable,
    input wire logic [4:0][1:0] i_half_off,
    input wire logic [4:0][15:0] i_core_out,
    input wire logic [4:0] i_exp_int_n,
    output logic [4:0][15:0] o_exp_inputs,
    // debug interface
    input wire logic [2:0] i_dbg_sel,
    input wire logic i_dbg_wr,
    input wire logic [15:0] i_dbg_data,
    input wire logic i_expander_reload,
    input wire logic i_expander_test_mode,
    output logic [15:0] o_expander_data_view,
    // status
    input wire logic [3:0] i_status_clr,
    output logic [3:0] o_serial_bus_status,
    output logic o_busy,
    // bus engine on the link clock
    output logic o_lnk_valid,
    output iehm_pkg::iehm_txn_t o_lnk_txn,
    input wire logic i_lnk_done,
    input wire logic [7:0] i_lnk_rdata,
    input wire logic [3:0] i_lnk_err
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    iehm_pkg::iehm_state_t state_r;
    logic [2:0] cur_r, rr_r, pick;
    logic [7:0] mask_r, job_nxt;
    logic found, go, go_prev_r, start, timed, req, done;
    logic [2:0] step;
    iehm_pkg::iehm_txn_t txn;
    iehm_pkg::iehm_res_t res;
    logic [4:0] int_s1_r, int_s2_r, en_prev_r;
    logic [4:0][6:0] addr_prev_r;
    logic [4:0][`IEHM_TMR_W-1:0] tmr_r;
    logic [4:0] cfg_pend_r, rel_pend_r, upd_el, rd_el, elig;
    logic [4:0][15:0] dir, want, sent_r;
    logic [15:0] dbg_data_r;

    // transactions may start only once loading is over and outside reset
    assign go = i_eeprom_done && i_normal_op && !i_fund_reset;
    assign o_busy = (state_r != iehm_pkg::IEHM_IDLE);

    // interrupt pins pass two flops before use
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            int_s1_r <= 5'h1f;
            int_s2_r <= 5'h1f;
        end else begin
            int_s1_r <= i_exp_int_n;
            int_s2_r <= int_s1_r;
        end
    end

    // edge history for address, enable and phase changes
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            addr_prev_r <= '0;
            en_prev_r <= 5'h00;
            go_prev_r <= 1'b0;
        end else begin
            addr_prev_r <= i_expander_bus_address;
            en_prev_r <= i_exp_enable;
            go_prev_r <= go;
        end
    end

    // ----------------------------------------
    // per expander view, pending work and update period
    // ----------------------------------------
    for (genvar g = 0; g < `IEHM_NUM_EXP; g++) begin : g_exp
        logic [15:0] core;
        logic is_led, is_pg, cfg_set, rel_set, sel_me, grant;
        assign is_led = (3'(g) == `IEHM_EXP_LED);
        assign is_pg = (3'(g) == `IEHM_EXP_PG);
        assign sel_me = (i_dbg_sel == 3'(g));
        assign grant = start && (pick == 3'(g));
        assign dir[g] = is_led ? `IEHM_DIR_LED : (is_pg ? `IEHM_DIR_PG : `IEHM_DIR_HP);
        // indicators lit low, hot-plug untouched, disabled halves negated
        assign core = is_led ? ~i_core_out[g] : i_core_out[g];
        assign want[g][7:0] = (i_expander_test_mode && sel_me) ? dbg_data_r[7:0] :
            (i_half_off[g][0] ? (is_led ? `IEHM_NEG_LED : `IEHM_NEG_HP) : core[7:0]);
        assign want[g][15:8] = (i_expander_test_mode && sel_me) ? dbg_data_r[15:8] :
            (i_half_off[g][1] ? (is_led ? `IEHM_NEG_LED : `IEHM_NEG_HP) : core[15:8]);
        // any output bit out of step wants a write, held off by the period
        assign upd_el[g] = |((want[g] ^ sent_r[g]) & ~dir[g]) && (tmr_r[g] == '0);
        assign rd_el[g] = !int_s2_r[g] && (tmr_r[g] == '0);
        assign elig[g] = i_exp_enable[g] && (cfg_pend_r[g] || rel_pend_r[g] || upd_el[g] || rd_el[g]);
        assign cfg_set = i_exp_enable[g] && ((i_expander_bus_address[g] != addr_prev_r[g]) ||
            !en_prev_r[g] || (go && !go_prev_r));
        assign rel_set = i_expander_reload && sel_me;

        // pending flags: a new cause in the grant cycle wins over the clear
        always_ff @(posedge i_clk_sys) begin
            if (!i_nrst) begin
                cfg_pend_r[g] <= 1'b0;
                rel_pend_r[g] <= 1'b0;
            end else begin
                cfg_pend_r[g] <= cfg_set || (cfg_pend_r[g] && !grant);
                rel_pend_r[g] <= rel_set || (rel_pend_r[g] && !(grant && !cfg_pend_r[g]));
            end
        end

        // period restarts whenever a rate limited write or read is granted
        always_ff @(posedge i_clk_sys) begin
            if (!i_nrst) begin
                tmr_r[g] <= '0;
            end else if (grant && timed) begin
                tmr_r[g] <= PERIOD_CYC - 1'b1;
            end else if (tmr_r[g] != '0) begin
                tmr_r[g] <= tmr_r[g] - 1'b1;
            end
        end
    end

    // ----------------------------------------
    // round robin arbiter and job selection
    // ----------------------------------------
    always_comb begin
        logic [3:0] cand;
        cand = 4'h0;
        pick = 3'h0;
        found = 1'b0;
        // scan starts after the last served expander
        for (int i = 1; i <= `IEHM_NUM_EXP; i++) begin
            cand = {1'b0, rr_r} + 4'(i);
            if (cand >= 4'(`IEHM_NUM_EXP)) begin
                cand = cand - 4'(`IEHM_NUM_EXP);
            end
            if (!found && elig[cand[2:0]]) begin
                found = 1'b1;
                pick = cand[2:0];
            end
        end
    end

    // configuration first, then reload, then timed work
    always_comb begin
        timed = 1'b0;
        if (cfg_pend_r[pick]) begin
            job_nxt = (pick == `IEHM_EXP_PG) ? `IEHM_CFG_MASK_PG : `IEHM_CFG_MASK;
        end else if (rel_pend_r[pick]) begin
            job_nxt = `IEHM_RD_MASK | ((pick == `IEHM_EXP_PG) ? `IEHM_UPD_MASK_PG : `IEHM_UPD_MASK);
        end else begin
            timed = 1'b1;
            job_nxt = (rd_el[pick] ? `IEHM_RD_MASK : 8'h00) |
                (upd_el[pick] ? ((pick == `IEHM_EXP_PG) ? `IEHM_UPD_MASK_PG : `IEHM_UPD_MASK) : 8'h00);
        end
    end

    assign start = (state_r == iehm_pkg::IEHM_IDLE) && go && go_prev_r && found; // no regrant on go edge

    // ----------------------------------------
    // step decode: lowest remaining step goes next
    // ----------------------------------------
    always_comb begin
        step = 3'h0;
        for (int k = 7; k >= 0; k--) begin
            if (mask_r[k]) begin
                step = 3'(k);
            end
        end
    end

    // transaction for the current step, data taken as it starts
    always_comb begin
        txn.addr = i_expander_bus_address[cur_r];
        txn.write = (step < `IEHM_STEP_RD_LO);
        txn.reg_idx = txn.write ? (step + `IEHM_REG_OUT_LO) : (step - `IEHM_STEP_RD_LO + `IEHM_REG_IN_LO);
        if (step == `IEHM_STEP_OUT_LO) begin
            txn.data = want[cur_r][7:0];
        end else if (step == `IEHM_STEP_OUT_HI) begin
            txn.data = want[cur_r][15:8];
        end else if (step == `IEHM_STEP_DIR_LO) begin
            txn.data = dir[cur_r][7:0];
        end else if (step == `IEHM_STEP_DIR_HI) begin
            txn.data = dir[cur_r][15:8];
        end else begin
            txn.data = `IEHM_INV_DATA;
        end
    end

    assign req = (state_r == iehm_pkg::IEHM_SEND) && go;

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            state_r <= iehm_pkg::IEHM_IDLE;
            cur_r <= 3'h0;
            rr_r <= 3'h0;
            mask_r <= 8'h00;
        end else begin
            case (state_r)
                iehm_pkg::IEHM_IDLE: begin
                    if (start) begin
                        cur_r <= pick;
                        rr_r <= pick;
                        mask_r <= job_nxt;
                        state_r <= iehm_pkg::IEHM_SEND;
                    end
                end
                iehm_pkg::IEHM_SEND: begin
                    // reset entry abandons the job, outputs keep their values
                    state_r <= go ? iehm_pkg::IEHM_WAIT : iehm_pkg::IEHM_IDLE;
                end
                iehm_pkg::IEHM_WAIT: begin
                    if (done) begin
                        mask_r[step] <= 1'b0;
                        state_r <= ((mask_r & ~(8'h01 << step)) == 8'h00) ?
                            iehm_pkg::IEHM_IDLE : iehm_pkg::IEHM_SEND;
                    end
                end
                default: begin
                    state_r <= iehm_pkg::IEHM_IDLE;
                end
            endcase
        end
    end

    // sent outputs and read inputs per expander
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            sent_r <= '0;
            o_exp_inputs <= '0;
        end else begin
            if (req && step == `IEHM_STEP_OUT_LO) begin
                sent_r[cur_r][7:0] <= txn.data;
            end
            if (req && step == `IEHM_STEP_OUT_HI) begin
                sent_r[cur_r][15:8] <= txn.data;
            end
            if (done && step == `IEHM_STEP_RD_LO) begin
                o_exp_inputs[cur_r][7:0] <= res.rdata;
            end
            if (done && step == `IEHM_STEP_RD_HI) begin
                o_exp_inputs[cur_r][15:8] <= res.rdata;
            end
        end
    end

    // sticky errors, a new error beats a clear in the same cycle
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            o_serial_bus_status <= 4'h0;
        end else begin
            o_serial_bus_status <= (o_serial_bus_status & ~i_status_clr) | (done ? res.err : 4'h0);
        end
    end

    // debug data store and view of the selected expander
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            dbg_data_r <= 16'h0000;
            o_expander_data_view <= 16'h0000;
        end else begin
            if (i_dbg_wr) begin
                dbg_data_r <= i_dbg_data;
            end
            if (i_dbg_sel < 3'(`IEHM_NUM_EXP)) begin
                o_expander_data_view <= (o_exp_inputs[i_dbg_sel] & dir[i_dbg_sel]) |
                    ((i_expander_test_mode ? dbg_data_r : sent_r[i_dbg_sel]) & ~dir[i_dbg_sel]);
            end else begin
                o_expander_data_view <= 16'h0000;
            end
        end
    end

    // ----------------------------------------
    // link crossing
    // ----------------------------------------
    iehm_xfer u_xfer (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_req(req),
        .i_txn(txn),
        .o_done(done),
        .o_res(res),
        .i_clk_link(i_clk_link),
        .o_lnk_valid(o_lnk_valid),
        .o_lnk_txn(o_lnk_txn),
        .i_lnk_done(i_lnk_done),
        .i_lnk_rdata(i_lnk_rdata),
        .i_lnk_err(i_lnk_err)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);

    sequence s_grant_timed;
        start && timed;
    endsequence

    gated_start_a: assert property (!go |-> !req) else $error("transaction while gated");
    idle_hold_a: assert property (!go && !o_busy |=> !o_busy) else $error("job started while gated");
    inv_zero_a: assert property (req && txn.write && (txn.reg_idx == 3'h4 || txn.reg_idx == 3'h5)
        |-> txn.data == 8'h00) else $error("inversion register not zero");
    pg_upper_a: assert property (req && cur_r == 3'h2 && txn.write |-> txn.reg_idx != 3'h3 &&
        (txn.reg_idx != 3'h7 || txn.data == 8'hff)) else $error("power good upper byte wrong");
    led_dir_a: assert property (req && cur_r == 3'h4 && txn.write && txn.reg_idx >= 3'h6
        |-> txn.data == 8'h00) else $error("indicator pins not outputs");
    cfg_order_a: assert property (start && cfg_pend_r[pick] |=> mask_r[0] && mask_r[7:6] == 2'b11)
        else $error("configuration missing steps");
    period_a: assert property (s_grant_timed |=> tmr_r[cur_r] == PERIOD_CYC - 1'b1 ##1
        tmr_r[cur_r] == PERIOD_CYC - 2'h2) else $error("update period not started");
    rate_a: assert property (s_grant_timed |-> tmr_r[pick] == '0) else $error("served inside period");
    err_sticky_a: assert property (done && res.err[0] |=> o_serial_bus_status[0])
        else $error("error not recorded");
    rr_fair_a: assert property (start && elig[rr_r] && elig != (5'h01 << rr_r) |-> pick != rr_r)
        else $error("arbiter repeated an expander");

endmodule : iehm_top

// ==== dv/iehm_exp_model.sv ====
/*
 * Model of the five expanders behind the link engine: answers each byte.
 * Assumes address bits 2:0 pick the expander; pins come from the bench.
 */
`timescale 1ns/1ps
module iehm_exp_model (
    // link handshake
    input wire logic i_clk_link,
    input wire logic i_valid,
    input wire iehm_pkg::iehm_txn_t i_txn,
    output logic o_done,
    output logic [7:0] o_rdata,
    output logic [3:0] o_err,
    // pins and fault injection
    input wire logic [4:0][15:0] i_pins,
    input wire logic [3:0] i_err_inj,
    output logic [4:0] o_int_n
);
    logic [4:0][15:0] last_r = '0;
    logic [2:0] cnt_r = 3'h0;
    logic ans_r = 1'b0;
    logic [2:0] k;
    assign k = i_txn.addr[2:0];
    initial begin
        o_done = 1'b0;
        o_rdata = 8'h00;
        o_err = 4'h0;
    end
    // open drain low while pins differ from last read
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            o_int_n[i] = (i_pins[i] == last_r[i]);
        end
    end
    // delay follows data bits so prompt and slow answers both occur
    always @(posedge i_clk_link) begin
        o_done <= 1'b0;
        o_rdata <= ~o_rdata; // no stale byte between answers
        o_err <= ~i_err_inj;
        if (!i_valid) begin
            cnt_r <= 3'h0;
            ans_r <= 1'b0;
        end else if (!ans_r && cnt_r > {1'b0, i_txn.data[1:0]}) begin
            o_done <= 1'b1;
            ans_r <= 1'b1;
            o_err <= i_err_inj;
            o_rdata <= i_txn.reg_idx[0] ? i_pins[k][15:8] : i_pins[k][7:0];
            if (!i_txn.write) begin
                last_r[k] <= i_pins[k];
            end
        end else begin
            cnt_r <= cnt_r + 3'h1;
        end
    end
endmodule : iehm_exp_model

// ==== dv/tb_iehm_top.sv ====
/*
 * Bench of the expander manager: checks each byte against queue model.
 * Assumes the expander model; period shortened to 50 cycles.
 */
`timescale 1ns/1ps
module tb_iehm_top;
    logic clk = 1'b0, lclk = 1'b0, nrst = 1'b0, ee = 1'b0, nop = 1'b0;
    logic fr = 1'b0, wr = 1'b0, rl = 1'b0, tm = 1'b0, lv, ld, bsy;
    logic [2:0] sel = 3'h0;
    logic [4:0] en = '0, int_n;
    logic [4:0][6:0] adr = {7'h24, 7'h23, 7'h22, 7'h21, 7'h20};
    logic [4:0][1:0] hoff = 10'h108;
    logic [4:0][15:0] core = '0, pins = '0, inp;
    logic [15:0] dd = '0, view;
    logic [3:0] sclr = '0, sts, ler, einj = '0;
    logic [7:0] lrd;
    iehm_pkg::iehm_txn_t lt;
    logic [11:0] q[5][$];
    time tq[5][$];
    time t1, t2;
    int err_total = 0, samples_checked = 0, ntx = 0, n;
    always #25 clk = ~clk;
    initial begin
        #7;
        forever #15 lclk = ~lclk;
    end
    iehm_top #(.PERIOD_CYC(20'd50)) dut (.i_clk_sys(clk), .i_clk_link(lclk), .i_nrst(nrst),
        .i_eeprom_done(ee), .i_normal_op(nop), .i_fund_reset(fr), .i_expander_bus_address(adr),
        .i_exp_enable(en), .i_half_off(hoff), .i_core_out(core), .i_exp_int_n(int_n),
        .o_exp_inputs(inp), .i_dbg_sel(sel), .i_dbg_wr(wr), .i_dbg_data(dd),
        .i_expander_reload(rl), .i_expander_test_mode(tm), .o_expander_data_view(view),
        .i_status_clr(sclr), .o_serial_bus_status(sts), .o_busy(bsy), .o_lnk_valid(lv),
        .o_lnk_txn(lt), .i_lnk_done(ld), .i_lnk_rdata(lrd), .i_lnk_err(ler));
    iehm_exp_model xm (.i_clk_link(lclk), .i_valid(lv), .i_txn(lt), .o_done(ld),
        .o_rdata(lrd), .o_err(ler), .i_pins(pins), .i_err_inj(einj), .o_int_n(int_n));
    // log each byte at the edge where the engine answers
    always @(posedge lclk) begin
        if (lv === 1'b1 && ld === 1'b1) begin
            q[lt.addr[2:0]].push_back({lt.reg_idx, lt.write, lt.data});
            tq[lt.addr[2:0]].push_back($time);
            ntx++;
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task end_sim;
        if (err_total == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    task automatic ck(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : ck
    // reads carry no data, so only register and direction compared
    task automatic tx(input int k, input logic [2:0] r, input logic w, input logic [7:0] d, output time t);
        logic [11:0] g;
        for (int i = 0; i < 4000 && q[k].size() == 0; i++) @(posedge clk);
        #1;
        if (q[k].size() == 0) begin
            ck(1'b0, "no byte");
            end_sim;
        end
        g = q[k].pop_front();
        t = tq[k].pop_front();
        ck(g[11:8] === {r, w} && (!w || g[7:0] === d), "byte");
    endtask : tx
    task automatic upd(input int k, input logic [15:0] o, output time t);
        time u;
        tx(k, 3'h2, 1'b1, o[7:0], t);
        if (k != 2) tx(k, 3'h3, 1'b1, o[15:8], u);
    endtask : upd
    task automatic rd(input int k, output time t);
        time u;
        tx(k, 3'h0, 1'b0, 8'h00, t);
        tx(k, 3'h1, 1'b0, 8'h00, u);
    endtask : rd
    task automatic cfg(input int k);
        logic [15:0] o, d;
        time t;
        o = (k == 4) ? ~core[k] : core[k];
        // switched-off halves go to their negated level, indicators dark high
        if (hoff[k][0]) o[7:0] = (k == 4) ? 8'hff : 8'h00;
        if (hoff[k][1]) o[15:8] = (k == 4) ? 8'hff : 8'h00;
        d = (k == 4) ? 16'h0000 : (k == 2) ? 16'hff0f : 16'h0f0f;
        upd(k, o, t);
        tx(k, 3'h4, 1'b1, 8'h00, t);
        tx(k, 3'h5, 1'b1, 8'h00, t);
        tx(k, 3'h6, 1'b1, d[7:0], t);
        tx(k, 3'h7, 1'b1, d[15:8], t);
        rd(k, t);
    endtask : cfg
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : cyc
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32262));
        for (int k = 0; k < 5; k++) begin
            pins[k] = (k == 3) ? 16'h0000 : 16'($urandom);
            core[k] = 16'($urandom) & ((k == 4) ? 16'hffff : (k == 2) ? 16'h00f0 : 16'hf0f0);
        end
        repeat (16) @(posedge clk);
        #1;
        nrst = 1'b1;
        en = 5'h17;
        nop = 1'b1;
        cyc(100);
        ck(ntx == 0 && bsy === 1'b0, "early");
        ee = 1'b1;
        for (int k = 0; k < 5; k++) if (k != 3) cfg(k);
        cyc(50);
        for (int k = 0; k < 5; k++) if (k != 3) ck(inp[k] === pins[k], "inputs");
        core[0] = core[0] ^ 16'h0010;
        upd(0, core[0], t1);
        core[0] = core[0] ^ 16'h8000;
        upd(0, core[0], t2);
        ck(t2 - t1 >= 2300, "update rate");
        pins[0] = pins[0] ^ 16'h0002;
        rd(0, t1);
        pins[0] = pins[0] ^ 16'h0100;
        rd(0, t2);
        ck(t2 - t1 >= 2300, "read rate");
        cyc(20);
        ck(inp[0] === pins[0], "read value");
        einj = 4'h5;
        rl = 1'b1;
        cyc(1);
        rl = 1'b0;
        upd(0, core[0], t1);
        rd(0, t1);
        einj = 4'h0;
        cyc(20);
        ck(sts === 4'h5, "status");
        ck(view === ((pins[0] & 16'h0f0f) | (core[0] & 16'hf0f0)), "view");
        sel = 3'h1;
        cyc(3);
        ck(view === ((pins[1] & 16'h0f0f) | (core[1] & 16'h00f0)), "select view");
        sel = 3'h5;
        cyc(3);
        ck(view === 16'h0000, "no expander");
        sel = 3'h0;
        cyc(3);
        sclr = 4'hf;
        cyc(1);
        sclr = 4'h0;
        cyc(5);
        ck(sts === 4'h0, "clear");
        // bit 6 always differs from the sent outputs, so an update must follow
        dd = core[0] ^ ((16'($urandom) & 16'hf0f0) | 16'h0040);
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
        tm = 1'b1;
        upd(0, dd, t1);
        dd = dd ^ 16'h8000;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
        upd(0, dd, t2);
        ck(t2 - t1 >= 2300, "test update rate");
        cyc(20);
        ck(view === ((pins[0] & 16'h0f0f) | (dd & 16'hf0f0)), "test view");
        fr = 1'b1;
        cyc(2);
        n = ntx;
        tm = 1'b0;
        core[0] = ~core[0] & 16'hf0f0;
        cyc(300);
        ck(ntx == n && bsy === 1'b0, "quiet");
        for (int k = 0; k < 5; k++) ck(q[k].size() == 0, "extra byte");
        end_sim;
    end
endmodule : tb_iehm_top
